// >>> rtctk_top.sv
`timescale 1ns/10ps
`include "rtctk_cfg.svh"
module rtctk_top #(
    parameter int unsigned TICK_DIV = `RTCTK_CLK_HZ * `RTCTK_TICK_S
) (
    input  wire logic        CLK_I,        // 10 MHz clock
    input  wire logic        RESET_I,      // Sync reset, high
    input  wire logic        CMD_VALID_I,  // Serial command word valid
    input  wire logic [15:0] CMD_WORD_I,   // Serial command word
    input  wire logic        MAIN_READY_I, // Main logic fully started
    output logic      [15:0] RD_DATA_O,    // Read answer word
    output logic             RD_VALID_O,   // Read answer strobe
    output logic             CAL_MODE_O,   // Calendar mode selected
    output logic             DST_EN_O,     // Daylight-saving enable
    output logic             FLASH_REQ_O,  // Flash backup request pulse
    output logic             SEC_TICK_O    // Second tick pulse
);
    import rtctk_pkg::*;

    // Below two the divider could never produce a one-cycle tick
    if (TICK_DIV < 2) begin : g_bad_div
        $error("TICK_DIV must be at least 2");
    end

    rtctk_time_t cur_reg, pend_reg, stage_reg, cur_next;
    rtctk_load_t load_reg;
    logic [7:0]  page_reg;
    logic        tick;
    logic        wr;
    logic [6:0]  addr;
    logic [7:0]  data;
    logic        cfg_wr;
    logic        year_wr;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    assign wr   = CMD_VALID_I && CMD_WORD_I[`RTCTK_CMD_W_BIT];
    assign addr = CMD_WORD_I[14:8];
    assign data = CMD_WORD_I[7:0];
    assign cfg_wr  = wr && page_reg == `RTCTK_PAGE_CFG;
    assign year_wr = wr && page_reg == `RTCTK_PAGE_TIME &&
                     addr == `RTCTK_ADDR_YM_HI;

    // Timekeeping runs regardless of the main logic state
    rtctk_tick #(
        .DIV     (TICK_DIV)
    ) u_tick (
        .clk_i   (CLK_I),
        .reset_i (RESET_I),
        .tick_o  (tick)
    );

    // ------------------------------------------------------------------
    // Second tick output
    // ------------------------------------------------------------------
    // Registered copy: it pulses in the cycle the counter shows the new
    // second, so a read started on it already sees the new time.
    always_ff @(posedge CLK_I) begin
        if (RESET_I) SEC_TICK_O <= 1'b0;
        else         SEC_TICK_O <= tick;
    end

    // ------------------------------------------------------------------
    // Page select
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RESET_I)
            page_reg <= `RTCTK_PAGE_TIME;
        else if (wr && addr == `RTCTK_ADDR_PAGE)
            page_reg <= data;
    end

    // ------------------------------------------------------------------
    // Configuration and command
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            CAL_MODE_O <= 1'b0;
            DST_EN_O   <= 1'b0;
        end else if (cfg_wr && addr == `RTCTK_ADDR_CFG_LO) begin
            CAL_MODE_O <= data[`RTCTK_CFG_CAL_BIT];
            DST_EN_O   <= data[`RTCTK_CFG_DST_BIT];
        end
    end

    // Only a request pulse: the backup itself lives outside this block
    always_ff @(posedge CLK_I) begin
        if (RESET_I)
            FLASH_REQ_O <= 1'b0;
        else
            FLASH_REQ_O <= cfg_wr && addr == `RTCTK_ADDR_CMD_LO &&
                           data[`RTCTK_CMD_FLASH_BIT];
    end

    // ------------------------------------------------------------------
    // Staging of written bytes; year write commits
    // ------------------------------------------------------------------
    // Bytes collect in stage_reg; only the year byte copies them to
    // pend_reg, so a half-written set never reaches the counter.
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            stage_reg <= '0;
        end else if (wr && page_reg == `RTCTK_PAGE_TIME) begin
            unique case (addr)
                `RTCTK_ADDR_MS_LO: stage_reg.sec  <= data[5:0];
                `RTCTK_ADDR_MS_HI: stage_reg.min  <= data[5:0];
                `RTCTK_ADDR_DH_LO: stage_reg.hour <= data[5:0];
                `RTCTK_ADDR_DH_HI: stage_reg.day  <= data[4:0];
                `RTCTK_ADDR_YM_LO: stage_reg.mon  <= data[3:0];
                `RTCTK_ADDR_YM_HI: stage_reg.year <= data[6:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            pend_reg <= '0;
        end else if (year_wr) begin
            pend_reg      <= stage_reg;
            pend_reg.year <= data[6:0];
        end
    end

    // Armed from the year write to the next tick. A year write in the
    // tick cycle keeps it armed, so that commit is not lost.
    always_ff @(posedge CLK_I) begin
        if (RESET_I)
            load_reg <= RTCTK_IDLE;
        else if (year_wr)
            load_reg <= RTCTK_ARMED;
        else if (tick)
            load_reg <= RTCTK_IDLE;
    end

    // ------------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------------
    function automatic logic [4:0] days_in(input logic [3:0] m,
                                           input logic [6:0] y);
        logic [4:0] d;
        d = 5'h1f;
        if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hb)
            d = 5'h1e;
        else if (m == 4'h2)
            d = (y[1:0] == 2'b00) ? 5'h1d : 5'h1c;
        return d;
    endfunction : days_in

    always_comb begin
        cur_next = cur_reg;
        if (cur_reg.sec >= `RTCTK_SEC_MAX) begin
            cur_next.sec = 6'h00;
            if (cur_reg.min >= `RTCTK_MIN_MAX) begin
                cur_next.min = 6'h00;
                if (CAL_MODE_O && cur_reg.hour >= `RTCTK_HOUR_MAX) begin
                    cur_next.hour = 6'h00;
                    if (cur_reg.day >= days_in(cur_reg.mon, cur_reg.year)) begin
                        cur_next.day = `RTCTK_DAY_MIN;
                        if (cur_reg.mon >= `RTCTK_MON_MAX) begin
                            cur_next.mon = `RTCTK_MON_MIN;
                            cur_next.year = (cur_reg.year >= `RTCTK_YEAR_MAX)
                                          ? 7'h00 : cur_reg.year + 7'h1;
                        end else begin
                            cur_next.mon = cur_reg.mon + 4'h1;
                        end
                    end else begin
                        cur_next.day = cur_reg.day + 5'h1;
                    end
                end else begin
                    // Elapsed mode, or calendar hour below 23: hours count up; in elapsed mode they wrap at field width
                    cur_next.hour = cur_reg.hour + 6'h1;
                end
            end else begin
                cur_next.min = cur_reg.min + 6'h1;
            end
        end else begin
            cur_next.sec = cur_reg.sec + 6'h1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I)
            cur_reg <= '0;
        else if (tick && load_reg == RTCTK_ARMED)
            cur_reg <= pend_reg;
        else if (tick)
            cur_reg <= cur_next;
    end

    // ------------------------------------------------------------------
    // Reads
    // ------------------------------------------------------------------
    // Reads answer only once the main logic has started; time keeps
    // counting while it is down.
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            RD_DATA_O  <= 16'h0000;
            RD_VALID_O <= 1'b0;
        end else begin
            RD_VALID_O <= 1'b0;
            if (CMD_VALID_I && !CMD_WORD_I[`RTCTK_CMD_W_BIT] &&
                MAIN_READY_I && page_reg == `RTCTK_PAGE_TIME) begin
                RD_VALID_O <= 1'b1;
                unique case (addr)
                    `RTCTK_ADDR_MS_LO:
                        RD_DATA_O <= {2'b00, cur_reg.min,
                                      2'b00, cur_reg.sec};
                    `RTCTK_ADDR_DH_LO:
                        RD_DATA_O <= {3'b000, cur_reg.day,
                                      2'b00, cur_reg.hour};
                    `RTCTK_ADDR_YM_LO:
                        RD_DATA_O <= {1'b0, cur_reg.year,
                                      4'h0, cur_reg.mon};
                    default:
                        RD_DATA_O <= 16'h0000;
                endcase
            end
        end
    end
endmodule : rtctk_top

// >>> rtctk_cfg.svh
`ifndef RTCTK_CFG_SVH
`define RTCTK_CFG_SVH
// ----------------------------------------------------------------------
// Operation
// - In elapsed-timer mode all time fields start at zero after reset; seconds, minutes and hours count up like a stopwatch, day, month and year stay put.
// - Written time bytes stay pending until the year byte is written, which commits them all.
// - Committed values appear in the time registers only at the first second tick after the year write.
// - Configuration bit 0 selects calendar mode when 1 and is set before the time is written.
// - Configuration bit 1 controls daylight-saving adjustment of the calendar; here it only drives DST_EN_O and the counter makes no adjustment.
// - Bit 3 of the global command register requests a flash backup of clock settings.
// - The first time register holds minutes in bits 13:8 and seconds in bits 5:0, each 0 to 59.
// - The second time register holds day in bits 12:8 (1 to 31) and hours in bits 5:0 (0 to 23).
// - The third time register holds year since 2000 in bits 14:8 (0 to 99) and month in bits 3:0.
// - The counter keeps running on its own supply while reads need normal operation.
// ----------------------------------------------------------------------
`define RTCTK_ADDR_PAGE     7'h00
`define RTCTK_ADDR_MS_LO    7'h78
`define RTCTK_ADDR_MS_HI    7'h79
`define RTCTK_ADDR_DH_LO    7'h7a
`define RTCTK_ADDR_DH_HI    7'h7b
`define RTCTK_ADDR_YM_LO    7'h7c
`define RTCTK_ADDR_YM_HI    7'h7d
`define RTCTK_ADDR_CFG_LO   7'h0a
`define RTCTK_ADDR_CMD_LO   7'h02
`define RTCTK_PAGE_TIME     8'h00
`define RTCTK_PAGE_CFG      8'h03
`define RTCTK_CMD_W_BIT     15
`define RTCTK_CFG_CAL_BIT   0
`define RTCTK_CFG_DST_BIT   1
`define RTCTK_CMD_FLASH_BIT 3
`define RTCTK_SEC_MAX       6'h3b
`define RTCTK_MIN_MAX       6'h3b
`define RTCTK_HOUR_MAX      6'h17
`define RTCTK_DAY_MIN       5'h01
`define RTCTK_MON_MIN       4'h1
`define RTCTK_MON_MAX       4'hc
`define RTCTK_YEAR_MAX      7'h63
`define RTCTK_CLK_HZ        10000000
`define RTCTK_TICK_S        1
`endif

// >>> rtctk_pkg.sv
package rtctk_pkg;
    typedef struct packed {
        logic [5:0] sec;
        logic [5:0] min;
        logic [5:0] hour;
        logic [4:0] day;
        logic [3:0] mon;
        logic [6:0] year;
    } rtctk_time_t;
    typedef enum logic [1:0] {
        RTCTK_IDLE   = 2'b01,
        RTCTK_ARMED  = 2'b10
    } rtctk_load_t;
endpackage : rtctk_pkg

// >>> rtctk_tick.sv
`timescale 1ns/10ps
`include "rtctk_cfg.svh"
module rtctk_tick #(
    parameter int unsigned DIV = `RTCTK_CLK_HZ * `RTCTK_TICK_S
) (
    input  wire logic clk_i,    // Clock
    input  wire logic reset_i,  // Sync reset
    output logic      tick_o    // One-cycle second pulse
);
    if (DIV < 2) begin : g_bad_div
        $error("DIV must be at least 2");
    end
    logic [31:0] cnt_reg;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_reg <= 32'h0;
            tick_o  <= 1'b0;
        end else if (cnt_reg == 32'(DIV - 1)) begin
            cnt_reg <= 32'h0;
            tick_o  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
            tick_o  <= 1'b0;
        end
    end
endmodule : rtctk_tick

// >>> rtctk_top_monitor.sv
`timescale 1ns/10ps
module rtctk_top_monitor #(
    parameter int unsigned TICK_DIV = 20
) (
    input wire logic        CLK_I,        // Clock
    input wire logic        RESET_I,      // Reset
    input wire logic        CMD_VALID_I,  // Valid
    input wire logic [15:0] CMD_WORD_I,   // Word
    input wire logic        MAIN_READY_I, // Ready
    input wire logic [15:0] RD_DATA_O,    // Data
    input wire logic        RD_VALID_O,   // Strobe
    input wire logic        CAL_MODE_O,   // Mode
    input wire logic        DST_EN_O,     // DST
    input wire logic        FLASH_REQ_O,  // Flash
    input wire logic        SEC_TICK_O    // Tick
);
    logic [7:0]  page_reg;
    logic [31:0] gap_reg;
    logic        wr, rd, fl_cmd, cfg_cmd;
    assign wr = CMD_VALID_I && CMD_WORD_I[15];
    assign rd = CMD_VALID_I && !CMD_WORD_I[15];
    assign fl_cmd = wr && page_reg == 8'h03 && CMD_WORD_I[14:8] == 7'h02
                    && CMD_WORD_I[3];
    assign cfg_cmd = wr && page_reg == 8'h03 && CMD_WORD_I[14:8] == 7'h0a;
    always_ff @(posedge CLK_I) begin
        if (RESET_I)
            page_reg <= 8'h00;
        else if (wr && CMD_WORD_I[14:8] == 7'h00)
            page_reg <= CMD_WORD_I[7:0];
    end
    // Gap stays at zero until the first tick, whose phase is unknown
    always_ff @(posedge CLK_I) begin
        if (RESET_I)
            gap_reg <= 32'h0;
        else if (SEC_TICK_O)
            gap_reg <= 32'h1;
        else if (gap_reg != 32'h0)
            gap_reg <= gap_reg + 32'h1;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    chk_read_answer: assert property (
        rd && MAIN_READY_I && page_reg == 8'h00 &&
        CMD_WORD_I[14:8] inside {7'h78, 7'h7a, 7'h7c} |=> RD_VALID_O)
        else $error("time read not answered");
    chk_read_refused: assert property (
        rd && !MAIN_READY_I |=> !RD_VALID_O)
        else $error("read answered while not ready");
    chk_read_cause: assert property (
        RD_VALID_O |-> $past(rd && MAIN_READY_I && page_reg == 8'h00))
        else $error("read strobe without accepted read");
    chk_flash_req: assert property (fl_cmd |=> FLASH_REQ_O)
        else $error("flash request missing");
    chk_flash_cause: assert property (
        FLASH_REQ_O |-> $past(fl_cmd))
        else $error("flash request without command");
    chk_cfg_load: assert property (
        cfg_cmd |=> {DST_EN_O, CAL_MODE_O} == $past(CMD_WORD_I[1:0]))
        else $error("config bits not loaded");
    chk_cfg_hold: assert property (
        !cfg_cmd |=> $stable(CAL_MODE_O) && $stable(DST_EN_O))
        else $error("config bits changed unasked");
    chk_reset_clear: assert property (
        $fell(RESET_I) |-> RD_DATA_O == 16'h0000 && !RD_VALID_O &&
        !FLASH_REQ_O && !SEC_TICK_O && !CAL_MODE_O)
        else $error("outputs not cleared by reset");
    chk_tick_gap: assert property (
        SEC_TICK_O && gap_reg != 32'h0 |-> gap_reg == TICK_DIV)
        else $error("second tick spacing wrong");
endmodule : rtctk_top_monitor
bind rtctk_top_tb rtctk_top_monitor #(.TICK_DIV(DIV)) i_mon (
    .CLK_I(clk_i), .RESET_I(reset_i), .CMD_VALID_I(cmd_valid),
    .CMD_WORD_I(cmd_word), .MAIN_READY_I(ready_i),
    .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid),
    .CAL_MODE_O(cal_mode), .DST_EN_O(dst_en),
    .FLASH_REQ_O(flash_req), .SEC_TICK_O(sec_tick));

// >>> rtctk_host.sv
`timescale 1ns/10ps
module rtctk_host (
    input  wire logic        clk_i,   // Clock
    output logic             valid_o, // Command valid
    output logic      [15:0] word_o   // Command word
);
    initial begin
        valid_o = 1'b0;
        word_o  = 16'h0000;
    end
    // Released word is inverted so stale data can never pass as fresh
    task automatic send(input logic [15:0] w);
        @(posedge clk_i);
        valid_o <= 1'b1;
        word_o  <= w;
        @(posedge clk_i);
        valid_o <= 1'b0;
        word_o  <= ~w;
        #1;
    endtask : send
    task automatic page(input logic [7:0] p);
        send({1'b1, 7'h00, p});
    endtask : page
endmodule : rtctk_host

// >>> rtctk_top_tb.sv
`timescale 1ns/10ps
module rtctk_top_tb;
    localparam int unsigned DIV = 20;
    logic        clk_i, reset_i, ready_i, cmd_valid, rd_valid;
    logic        cal_mode, dst_en, flash_req, sec_tick;
    logic [15:0] cmd_word, rd_data;
    int          n_mismatch, samples_checked;
    rtctk_top #(.TICK_DIV(DIV)) i_dut (
        .CLK_I(clk_i), .RESET_I(reset_i), .CMD_VALID_I(cmd_valid),
        .CMD_WORD_I(cmd_word), .MAIN_READY_I(ready_i), .RD_DATA_O(rd_data),
        .RD_VALID_O(rd_valid), .CAL_MODE_O(cal_mode), .DST_EN_O(dst_en),
        .FLASH_REQ_O(flash_req), .SEC_TICK_O(sec_tick));
    rtctk_host i_host (.clk_i(clk_i), .valid_o(cmd_valid), .word_o(cmd_word));
    task automatic check(input string what, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic rd(input logic [6:0] a, input logic [15:0] e, input bit ok);
        i_host.send({1'b0, a, 8'h00});
        check("read strobe", {15'h0, ok}, {15'h0, rd_valid});
        if (ok)
            check("read data", e, rd_data);
    endtask : rd
    task automatic wait_tick;
        int k;
        k = 0;
        do begin
            @(posedge clk_i);
            #1;
            k++;
        end while (sec_tick !== 1'b1 && k < 64);
        check("tick", 16'h1, {15'h0, sec_tick});
    endtask : wait_tick
    task automatic do_reset;
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
    endtask : do_reset
    task automatic t_elapsed;
        rd(7'h78, 16'h0000, 1'b1);
        rd(7'h7c, 16'h0000, 1'b1);
        repeat (3) wait_tick;
        rd(7'h78, 16'h0003, 1'b1);
        $display("test elapsed done");
    endtask : t_elapsed
    task automatic t_refuse;
        @(posedge clk_i);
        ready_i <= 1'b0;
        rd(7'h78, 16'h0000, 1'b0);
        @(posedge clk_i);
        ready_i <= 1'b1;
        i_host.page(8'h03);
        rd(7'h78, 16'h0000, 1'b0);
        i_host.send(16'h8200);
        check("flash idle", 16'h0, {15'h0, flash_req});
        i_host.send(16'h8208);
        check("flash pulse", 16'h1, {15'h0, flash_req});
        i_host.send(16'h8a03);
        check("config", 16'h3, {14'h0, dst_en, cal_mode});
        i_host.page(8'h00);
        i_host.send(16'h8a00);
        check("config kept", 16'h3, {14'h0, dst_en, cal_mode});
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_calendar;
        wait_tick;
        i_host.send(16'hf83a);
        i_host.send(16'hf93b);
        i_host.send(16'hfa17);
        i_host.send(16'hfb1f);
        i_host.send(16'hfc0c);
        rd(7'h7a, 16'h0000, 1'b1);
        i_host.send(16'hfd63);
        rd(7'h7a, 16'h0000, 1'b1);
        wait_tick;
        rd(7'h78, 16'h3b3a, 1'b1);
        rd(7'h7a, 16'h1f17, 1'b1);
        rd(7'h7c, 16'h630c, 1'b1);
        rd(7'h79, 16'h0000, 1'b1);
        repeat (2) wait_tick;
        rd(7'h78, 16'h0000, 1'b1);
        rd(7'h7a, 16'h0100, 1'b1);
        rd(7'h7c, 16'h0001, 1'b1);
        do_reset;
        rd(7'h7a, 16'h0000, 1'b1);
        check("mode", 16'h0, {15'h0, cal_mode});
        $display("test calendar done");
    endtask : t_calendar
    task automatic close_out;
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        n_mismatch++;
        close_out;
    end
    initial begin
        reset_i = 1'b1;
        ready_i = 1'b1;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        t_elapsed;
        t_refuse;
        t_calendar;
        close_out;
    end
endmodule : rtctk_top_tb
